// ===== flash_host_pkg.sv
// Constants shared by the flash host controller and its sector decoder.
// Assumes a 40 MHz system clock and a single flash device on the pins.
package flash_host_pkg;
  localparam int          WORD_ADDR_W   = 18;        // Word address width.
  localparam int          BYTE_ADDR_W   = 19;        // Byte address width.
  localparam int          DATA_W        = 16;        // Full data bus width.
  localparam int          BYTE_W        = 8;         // Byte lane width.
  localparam int          SECTOR_W      = 4;         // Sector number width.
  localparam logic [3:0]  SECTOR_COUNT  = 4'hb;      // Eleven sectors.
  localparam int          CLK_MHZ       = 40;        // System clock rate.
  localparam int          T_SETUP_NS    = 50;        // Strobe setup and access time.
  localparam int          T_PULSE_NS    = 50;        // Least strobe low time.
  localparam int          T_RESET_NS    = 500;       // Least reset pulse width.
  localparam int          SETUP_CYC     = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          PULSE_CYC     = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int          RESET_CYC     = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W         = 8;         // Width of the phase counter.
  // Top-boot boot block fields on word address bits 17:12.
  localparam logic [3:0]  TOP_S7_HI     = 4'he;      // Bits 17:14 of sector 7.
  localparam logic [5:0]  TOP_S8_HI     = 6'h3c;     // Bits 17:12 of sector 8.
  localparam logic [5:0]  TOP_S9_HI     = 6'h3d;     // Bits 17:12 of sector 9.
  localparam logic [4:0]  TOP_S10_HI    = 5'h1f;     // Bits 17:13 of sector 10.
  // Bottom-boot boot block fields on word address bits 17:12.
  localparam logic [4:0]  BOT_S0_HI     = 5'h00;     // Bits 17:13 of sector 0.
  localparam logic [5:0]  BOT_S1_HI     = 6'h02;     // Bits 17:12 of sector 1.
  localparam logic [5:0]  BOT_S2_HI     = 6'h03;     // Bits 17:12 of sector 2.
  localparam logic [3:0]  BOT_S3_HI     = 4'h1;      // Bits 17:14 of sector 3.
  // Bus cycle kinds requested by the user side.
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RESET} op_t;
endpackage

// ===== flash_sector_decode.sv
// Sector decoder: maps a word address to the sector number for either boot variant.
// Assumes the caller supplies word address bits 17:12.
module flash_sector_decode
  import flash_host_pkg::*;
(
  input  wire logic [5:0]          addr_hi,    // Word address bits 17:12.
  input  wire logic                top_boot,   // High for the top-boot variant.
  output logic [flash_host_pkg::SECTOR_W-1:0] sector  // Decoded sector number.
);
  import flash_host_pkg::*;

  // Uniform 64 KB sectors decode on bits 17:15 alone.
  wire [3:0] uniform_top = {1'b0, addr_hi[5:3]};        // Top variant: S0..S6.
  wire [3:0] uniform_bot = {1'b0, addr_hi[5:3]} + 4'h3; // Bottom variant: S4..S10.
  // Top-boot boot block on bits 17:12.
  wire [3:0] top_sec =
      (addr_hi[5:2] == TOP_S7_HI)  ? 4'h7 :
      (addr_hi      == TOP_S8_HI)  ? 4'h8 :
      (addr_hi      == TOP_S9_HI)  ? 4'h9 :
      (addr_hi[5:1] == TOP_S10_HI) ? 4'ha :
      uniform_top;
  // Bottom-boot boot block on bits 17:12.
  wire [3:0] bot_sec =
      (addr_hi[5:1] == BOT_S0_HI)  ? 4'h0 :
      (addr_hi      == BOT_S1_HI)  ? 4'h1 :
      (addr_hi      == BOT_S2_HI)  ? 4'h2 :
      (addr_hi[5:2] == BOT_S3_HI)  ? 4'h3 :
      uniform_bot;
  // Select the variant.
  assign sector = top_boot ? top_sec : bot_sec;
endmodule // flash_sector_decode

// ===== flash_host_ctrl.sv
// Host controller that runs read, write and reset cycles on the flash pins.
// Assumes all pin inputs are synchronous to sys_clk and one request at a time.
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int SETUP = flash_host_pkg::SETUP_CYC,  // Cycles before the strobe.
  parameter int PULSE = flash_host_pkg::PULSE_CYC,  // Cycles the strobe stays low.
  parameter int RST_W = flash_host_pkg::RESET_CYC   // Cycles reset stays low.
) (
  input  wire logic                                    sys_clk,        // System clock.
  input  wire logic                                    rst,            // Synchronous reset.
  input  wire logic                                    req_valid,      // Request strobe.
  output logic                                         req_ready,      // Idle and able to take a request.
  input  wire flash_host_pkg::op_t                     req_op,         // Read, write or reset.
  input  wire logic                                    req_byte,       // High for byte width.
  input  wire logic [flash_host_pkg::BYTE_ADDR_W-1:0]  req_addr,       // Byte or word address.
  input  wire logic [flash_host_pkg::DATA_W-1:0]       req_wdata,      // Write data.
  input  wire logic                                    top_boot,       // Boot variant strap.
  input  wire logic                                    wait_ready,     // High to stall reads while busy.
  output logic                                         rsp_valid,      // One-cycle completion pulse.
  output logic [flash_host_pkg::DATA_W-1:0]            rsp_rdata,      // Read data.
  output logic [flash_host_pkg::SECTOR_W-1:0]          rsp_sector,     // Sector of the last request.
  output logic                                         dev_busy,       // Registered busy level.
  output logic [flash_host_pkg::WORD_ADDR_W-1:0]       addr_pin,       // Address pins.
  input  wire logic [flash_host_pkg::DATA_W-1:0]       dq_in,          // Data pins as read.
  output logic [flash_host_pkg::DATA_W-1:0]            dq_out,         // Data pins driven.
  output logic                                         dq_oe_low,      // Drive enable, bits 7:0.
  output logic                                         dq_oe_mid,      // Drive enable, bits 14:8.
  output logic                                         dq_oe_top,      // Drive enable, bit 15.
  output logic                                         byte_mode_n,    // Width select, low for byte.
  output logic                                         chip_sel_n,     // Chip select.
  output logic                                         out_en_n,       // Output enable.
  output logic                                         wr_strobe_n,    // Write strobe.
  output logic                                         hw_reset_n,     // Hardware reset.
  input  wire logic                                    op_done_flag    // Ready/busy, low while busy.
);
  import flash_host_pkg::*;

  // Refuse timing counts that the phase counter cannot hold, at elaboration.
  if (SETUP < 1 || PULSE < 1 || RST_W < 1 || SETUP >= (1 << CNT_W) || PULSE >= (1 << CNT_W) ||
      RST_W >= (1 << CNT_W)) begin : gen_bad_timing
    $error("Timing counts out of range.");
  end

  // Cycle phases.
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RESET, ST_WAIT} state_t;

  state_t               state_reg, state_next;     // Phase register.
  logic [CNT_W-1:0]     cnt_reg,   cnt_next;       // Phase counter.
  op_t                  op_reg;                    // Latched operation.
  logic                 byte_reg;                  // Latched width.
  logic [BYTE_ADDR_W-1:0] addr_reg;                // Latched address.
  logic [DATA_W-1:0]    wdata_reg;                 // Latched write data.
  logic                 cmd_written_reg;           // A write ended since last reset.
  logic [SECTOR_W-1:0]  sector_w;                  // Decoded sector.

  // Sector decode of the request's word address.
  wire [WORD_ADDR_W-1:0] word_addr = req_byte ? req_addr[BYTE_ADDR_W-1:1]
                                              : req_addr[WORD_ADDR_W-1:0];
  flash_sector_decode u_dec (
    .addr_hi  (word_addr[17:12]),
    .top_boot (top_boot),
    .sector   (sector_w)
  );

  // Busy is only trusted once a write strobe has completed.
  wire busy_seen   = cmd_written_reg && !op_done_flag;
  wire read_stall  = wait_ready && busy_seen && req_op == OP_READ;
  wire take        = state_reg == ST_IDLE && req_valid && !read_stall;
  wire cnt_done    = cnt_reg == '0;
  wire is_write    = op_reg == OP_WRITE;

  // Next-phase selection.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_done ? cnt_reg : cnt_reg - 1'b1;
    case (state_reg)
      ST_IDLE: begin
        if (take && req_op == OP_RESET) begin
          state_next = ST_RESET;
          cnt_next   = CNT_W'(RST_W - 1);
        end else if (take) begin
          state_next = ST_SETUP;
          cnt_next   = CNT_W'(SETUP - 1);
        end
      end
      ST_SETUP: begin
        if (cnt_done) begin
          state_next = ST_STROBE;
          cnt_next   = CNT_W'(PULSE - 1);
        end
      end
      ST_STROBE: begin
        if (cnt_done) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_next = ST_IDLE;
      end
      ST_RESET: begin
        if (cnt_done) begin
          state_next = ST_WAIT;
          cnt_next   = CNT_W'(SETUP - 1);
        end
      end
      ST_WAIT: begin
        if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Phase and request latches.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      op_reg    <= OP_READ;
      byte_reg  <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (take) begin
        op_reg    <= req_op;
        byte_reg  <= req_byte;
        addr_reg  <= req_addr;
        wdata_reg <= req_wdata;
      end
    end
  end

  // Pin drive values for the next cycle.
  wire active_next = state_next == ST_SETUP || state_next == ST_STROBE || state_next == ST_HOLD;
  wire op_w_next   = take ? (req_op == OP_WRITE) : is_write;
  wire byte_next   = take ? req_byte : byte_reg;
  wire [BYTE_ADDR_W-1:0] a_next = take ? req_addr : addr_reg;
  wire [DATA_W-1:0] d_next = take ? req_wdata : wdata_reg;
  wire drive_next  = active_next && op_w_next;
  wire in_reset    = state_next == ST_RESET;

  // Pin registers; address and data stay steady through the strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chip_sel_n  <= 1'b1;
      out_en_n    <= 1'b1;
      wr_strobe_n <= 1'b1;
      hw_reset_n  <= 1'b0;
      byte_mode_n <= 1'b1;
      addr_pin    <= '0;
      dq_out      <= '0;
      dq_oe_low   <= 1'b0;
      dq_oe_mid   <= 1'b0;
      dq_oe_top   <= 1'b0;
    end else begin
      hw_reset_n  <= !in_reset;
      chip_sel_n  <= !active_next;
      out_en_n    <= !(active_next && !op_w_next && state_next != ST_HOLD);
      wr_strobe_n <= !(state_next == ST_STROBE && op_w_next);
      if (take) begin
        byte_mode_n <= !req_byte;
        addr_pin    <= req_byte ? a_next[BYTE_ADDR_W-1:1] : a_next[WORD_ADDR_W-1:0];
      end
      dq_out      <= byte_next ? {a_next[0], 7'h00, d_next[BYTE_W-1:0]} : d_next;
      dq_oe_low   <= drive_next;
      dq_oe_mid   <= drive_next && !byte_next;
      dq_oe_top   <= active_next && (byte_next || op_w_next);
    end
  end

  // Answer side: data sampled at the end of the strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid       <= 1'b0;
      rsp_rdata       <= '0;
      rsp_sector      <= '0;
      req_ready       <= 1'b0;
      dev_busy        <= 1'b0;
      cmd_written_reg <= 1'b0;
    end else begin
      rsp_valid <= state_reg == ST_HOLD || (state_reg == ST_WAIT && cnt_done);
      if (state_reg == ST_STROBE && cnt_done && !is_write) begin
        rsp_rdata <= byte_reg ? {8'h00, dq_in[BYTE_W-1:0]} : dq_in;
      end
      if (take) begin
        rsp_sector <= sector_w;
      end
      req_ready <= state_next == ST_IDLE;
      dev_busy  <= busy_seen;
      if (state_reg == ST_RESET) begin
        cmd_written_reg <= 1'b0;
      end else if (state_reg == ST_HOLD && is_write) begin
        cmd_written_reg <= 1'b1;
      end
    end
  end
endmodule // flash_host_ctrl

// ===== flash_dev_model.sv
// Behavioural flash device facing the host controller pins.
// Assumes the bench resolves the shared data lines and feeds them back as bus.
module flash_dev_model #(
  parameter int BUSY_CYC = 10  // Cycles the device stays busy after a write.
) (
  input  wire logic        clk,      // Time base for the busy count only.
  input  wire logic [17:0] addr,     // Address pins.
  input  wire logic [15:0] bus,      // Resolved data lines.
  input  wire logic        byte_n,   // Width select, low for byte.
  input  wire logic        ce_n,     // Chip select.
  input  wire logic        oe_n,     // Output enable.
  input  wire logic        we_n,     // Write strobe.
  input  wire logic        reset_n,  // Hardware reset.
  output logic [15:0]      q,        // Read data driven.
  output logic [15:0]      q_oe,     // Per-line drive enable.
  output wire logic        ready     // Ready level, low while busy.
);
  logic [15:0] mem [logic [17:0]];  // Written words; others read erased.
  logic [18:0] wa;                  // Latched write address.
  logic [15:0] cur;                 // Word being merged.
  int          busy;                // Remaining busy cycles.
  function automatic logic [15:0] rd(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // Drive lines only in a qualified read; show inverted data while busy.
  always @* begin
    q_oe = 16'h0000;
    q = 16'h0000;
    if (reset_n && !ce_n && !oe_n) begin
      q_oe = byte_n ? 16'hffff : 16'h00ff;
      q = (busy > 0) ? ~rd(addr) : rd(addr);
      if (!byte_n) begin
        q = bus[15] ? {8'h00, q[15:8]} : {8'h00, q[7:0]};
      end
    end
  end
  // Address is latched as the strobe falls.
  always @(negedge we_n) begin
    if (reset_n && !ce_n && oe_n) wa = {addr, bus[15]};
  end
  // Data is latched as the strobe rises and starts the busy time.
  always @(posedge we_n) begin
    if (reset_n && !ce_n && oe_n) begin
      cur = rd(wa[18:1]);
      if (byte_n) cur = bus;
      else if (wa[0]) cur[15:8] = bus[7:0];
      else cur[7:0] = bus[7:0];
      mem[wa[18:1]] = cur;
      busy = BUSY_CYC;
    end
  end
  // Reset aborts the operation at once; the countdown is non-blocking so the
  // host samples the ready level of the previous cycle, not a racing update.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy <= 0;
    else if (busy > 0) busy <= busy - 1;
  end
  assign ready = (busy == 0);
endmodule  // flash_dev_model

// ===== flash_host_ctrl_asserts.sv
// Pin protocol checks for the flash host controller.
// Assumes it is bound into flash_host_ctrl and sees only its ports.
module flash_host_ctrl_asserts
  import flash_host_pkg::*;
#(
  parameter int SETUP = 2,  // Cycles before the strobe.
  parameter int PULSE = 2,  // Cycles the strobe stays low.
  parameter int RST_W = 20  // Cycles reset stays low.
) (
  input wire logic                 sys_clk,      // System clock.
  input wire logic                 rst,          // Synchronous reset.
  input wire logic                 req_ready,    // Idle flag.
  input wire flash_host_pkg::op_t  req_op,       // Cycle kind.
  input wire logic                 wait_ready,   // Read stall enable.
  input wire logic                 rsp_valid,    // Completion pulse.
  input wire logic                 dev_busy,     // Busy level.
  input wire logic [17:0]          addr_pin,     // Address pins.
  input wire logic [15:0]          dq_out,       // Driven data.
  input wire logic                 dq_oe_low,    // Low lane enable.
  input wire logic                 dq_oe_mid,    // Middle lane enable.
  input wire logic                 dq_oe_top,    // Top line enable.
  input wire logic                 byte_mode_n,  // Width select.
  input wire logic                 chip_sel_n,   // Chip select.
  input wire logic                 out_en_n,     // Output enable.
  input wire logic                 wr_strobe_n,  // Write strobe.
  input wire logic                 hw_reset_n,   // Hardware reset.
  input wire logic                 op_done_flag  // Ready level, low while busy.
);
  localparam int RW_DLY = SETUP + PULSE + 1;  // Idle drop to completion.
  localparam int RS_DLY = RST_W + SETUP;      // Same for a reset cycle.
  logic [7:0] low_cnt_reg;                    // Reset pin low time.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Count how long the reset pin has been low.
  always_ff @(posedge sys_clk) begin
    if (rst || hw_reset_n) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_reg + 8'h01;
  end
  sequence rw_taken;
    $fell(req_ready) && $past(req_op) != OP_RESET;
  endsequence
  sequence rst_taken;
    $fell(req_ready) && $past(req_op) == OP_RESET;
  endsequence
  wr_qual_a: assert property (!wr_strobe_n |-> !chip_sel_n && out_en_n && hw_reset_n)
    else $error("Write strobe outside a write cycle.");
  rd_float_a: assert property (!out_en_n |-> !chip_sel_n && wr_strobe_n && !dq_oe_low && !dq_oe_mid)
    else $error("Read cycle with data lines driven.");
  byte_lane_a: assert property (!byte_mode_n |-> !dq_oe_mid)
    else $error("Unused lines driven in byte mode.");
  byte_lsb_a: assert property (!byte_mode_n && !chip_sel_n |-> dq_oe_top)
    else $error("Byte address bit not driven.");
  rst_quiet_a: assert property (!hw_reset_n |-> chip_sel_n && wr_strobe_n && !dq_oe_low)
    else $error("Access during hardware reset.");
  rst_width_a: assert property ($rose(hw_reset_n) && low_cnt_reg > 8'h01 |-> low_cnt_reg == 8'(RST_W))
    else $error("Reset pulse width wrong.");
  addr_hold_a: assert property ($fell(wr_strobe_n) |-> $stable(addr_pin) && $stable(byte_mode_n))
    else $error("Address moved at strobe fall.");
  data_hold_a: assert property ($rose(wr_strobe_n) |-> !chip_sel_n && $stable(dq_out))
    else $error("Data moved at strobe rise.");
  op_time_a: assert property (rw_taken |-> ##RW_DLY rsp_valid)
    else $error("Access completion late or early.");
  rst_time_a: assert property (rst_taken |-> ##RS_DLY rsp_valid)
    else $error("Reset completion late or early.");
  busy_gate_a: assert property (wait_ready && dev_busy && !op_done_flag && req_ready |=> out_en_n)
    else $error("Read started while busy.");
  rst_busy_a: assert property (!hw_reset_n ##1 !hw_reset_n |-> !dev_busy)
    else $error("Busy reported across reset.");
endmodule  // flash_host_ctrl_asserts
bind flash_host_ctrl flash_host_ctrl_asserts #(.SETUP(SETUP), .PULSE(PULSE), .RST_W(RST_W)) chk (
  .sys_clk, .rst, .req_ready, .req_op, .wait_ready, .rsp_valid, .dev_busy, .addr_pin, .dq_out,
  .dq_oe_low, .dq_oe_mid, .dq_oe_top, .byte_mode_n, .chip_sel_n, .out_en_n, .wr_strobe_n, .hw_reset_n,
  .op_done_flag);

// ===== flash_bus_port_sector_decode_bench.sv
// Self-checking bench for the flash host controller with a device model.
// Assumes the package, design, model and checker are compiled before it.
module flash_bus_port_sector_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;
  localparam int SETUP_B = 1;  // Cycles before the strobe in this bench.
  localparam int PULSE_B = 1;  // Cycles the strobe stays low in this bench.
  localparam int RST_B   = 2;  // Cycles the reset pin stays low in this bench.
  logic sys_clk, rst, req_valid, req_byte, top_boot, wait_ready, tog;
  op_t         req_op;
  logic [18:0] req_addr;
  logic [15:0] req_wdata, rdata;
  wire         req_ready, rsp_valid, dev_busy, oe_lo, oe_mid, oe_top, byte_n, ce_n, oe_n, we_n, rs_n, flag;
  wire  [15:0] rsp_rdata, dq_out, dev_q, dev_oe;
  wire  [3:0]  rsp_sector;
  wire  [17:0] addr_pin;
  wire  [15:0] dut_oe = {oe_top, {7{oe_mid}}, {8{oe_lo}}};
  // Undriven lines toggle so stale values never pass.
  wire  [15:0] bus = (dut_oe & dq_out) | (dev_oe & dev_q) | (~dut_oe & ~dev_oe & {16{tog}});
  int failures, num_checks;
  int aa[13] = '{'h0ffff, 'h6ffff, 'h70000, 'h77fff, 'h78000, 'h7a000, 'h7c000,
                 'h03fff, 'h04000, 'h06000, 'h08000, 'h10000, 'h7ffff};
  int sa[13] = '{0, 6, 7, 7, 8, 9, 10, 0, 1, 2, 3, 4, 10};
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) tog <= ~tog;
  flash_host_ctrl #(.SETUP(SETUP_B), .PULSE(PULSE_B), .RST_W(RST_B)) dut (.sys_clk, .rst, .req_valid, .req_ready,
    .req_op, .req_byte, .req_addr, .req_wdata, .top_boot, .wait_ready, .rsp_valid, .rsp_rdata,
    .rsp_sector, .dev_busy, .addr_pin, .dq_in(bus), .dq_out, .dq_oe_low(oe_lo), .dq_oe_mid(oe_mid),
    .dq_oe_top(oe_top), .byte_mode_n(byte_n), .chip_sel_n(ce_n), .out_en_n(oe_n),
    .wr_strobe_n(we_n), .hw_reset_n(rs_n), .op_done_flag(flag));
  flash_dev_model dev (.clk(sys_clk), .addr(addr_pin), .bus, .byte_n, .ce_n, .oe_n, .we_n,
    .reset_n(rs_n), .q(dev_q), .q_oe(dev_oe), .ready(flag));
  task automatic tally_and_finish;
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request: wait until taken, then time the completion pulse.
  task automatic do_op(input op_t op, input logic bt, input logic [18:0] a, input logic [15:0] d);
    int n;
    int lat;
    logic seen, taken;
    n = 0;
    // Completion comes right after the hold phase, or right after the reset wait.
    lat = (op == OP_RESET) ? RST_B + SETUP_B : SETUP_B + PULSE_B + 1;
    taken = 1'b0;
    req_op = op;
    req_byte = bt;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    seen = req_ready;
    while (!taken && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
      taken = seen && !req_ready;
      seen = req_ready;
    end
    req_valid = 1'b0;
    if (!taken) begin
      failures++;
      tally_and_finish();
    end
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      failures++;
      tally_and_finish();
    end
    check(16'(n), 16'(lat));
    rdata = rsp_rdata;
  endtask
  task automatic word_rw;
    do_op(OP_WRITE, 1'b0, 19'h05555, 16'h1234);
    do_op(OP_READ, 1'b0, 19'h05555, 16'h0000);
    check(rdata, 16'h1234);
  endtask
  task automatic byte_rw;
    do_op(OP_WRITE, 1'b1, 19'h12345, 16'h5aa5);
    do_op(OP_READ, 1'b1, 19'h12345, 16'h0000);
    check(rdata, 16'h00a5);
    do_op(OP_READ, 1'b1, 19'h12344, 16'h0000);
    check(rdata, 16'h00ff);
    do_op(OP_READ, 1'b0, 19'h091a2, 16'h0000);
    check(rdata, 16'ha5ff);
  endtask
  // Sector map for both variants; odd entries go as word addresses.
  task automatic sectors;
    for (int i = 0; i < 13; i++) begin
      top_boot = (i < 7);
      do_op(OP_READ, !i[0], i[0] ? 19'(aa[i] >> 1) : 19'(aa[i]), 16'h0000);
      check(16'(rsp_sector), 16'(sa[i]));
    end
  endtask
  task automatic hw_reset;
    do_op(OP_WRITE, 1'b0, 19'h00100, 16'hbeef);
    do_op(OP_RESET, 1'b0, 19'h00000, 16'h0000);
    check(16'(flag), 16'h0001);
    wait_ready = 1'b0;
    do_op(OP_READ, 1'b0, 19'h00100, 16'h0000);
    check(rdata, 16'hbeef);
  endtask
  initial begin
    rst = 1'b1;
    tog = 1'b0;
    req_valid = 1'b0;
    req_op = OP_READ;
    req_byte = 1'b0;
    req_addr = 19'h00000;
    req_wdata = 16'h0000;
    top_boot = 1'b0;
    wait_ready = 1'b1;
    failures = 0;
    num_checks = 0;
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    word_rw();
    byte_rw();
    sectors();
    hw_reset();
    tally_and_finish();
  end
endmodule  // flash_bus_port_sector_decode_bench
